// ### shared/vbi_insert_pkg.sv
// Package: register map, field layout and constants for the VBI inserter
package vbi_insert_pkg;
	// Register block base above the mapped register base
	localparam logic [19:0] BLOCK_BASE          = 20'h68000;
	localparam logic [19:0] CAPTION_CONTROL     = 20'h68090;
	localparam logic [19:0] CAPTION_DATA_ONE    = 20'h68094;
	localparam logic [19:0] CAPTION_DATA_TWO    = 20'h68098;
	localparam logic [19:0] WIDESCREEN_CONTROL  = 20'h680b0;
	localparam logic [19:0] WIDESCREEN_PAYLOAD  = 20'h680b4;
	localparam logic [19:0] HORIZ_LUMA_BASE     = 20'h68100;
	localparam logic [19:0] HORIZ_CHROMA_BASE   = 20'h68200;
	localparam logic [19:0] VERT_LUMA_BASE      = 20'h68300;
	localparam logic [19:0] VERT_CHROMA_BASE    = 20'h68400;
	localparam int          HORIZ_WORDS         = 60;
	localparam int          VERT_WORDS          = 43;
	localparam logic [31:0] REG_RESET           = 32'h0000_0000;
	// Field positions
	localparam int ENABLE_BIT      = 31;
	localparam int CC_FIELD_BIT    = 27;
	localparam int WIDESCREEN_FIELD_SELECT_BIT   = 30;
	localparam int OFFSET_LSB      = 16;
	localparam int OFFSET_W        = 10;
	localparam int LINE_LSB        = 0;
	localparam int LINE_W          = 6;
	localparam int DIV_LSB         = 8;
	localparam int DIV_W           = 7;
	localparam int CHAR_W          = 7;
	localparam int CHAR_HI_LSB     = 8;
	localparam int QUEUE_FULL_BIT  = 31;
	localparam int WIDESCREEN_PAYLOAD_W      = 14;
	// Caption bit timing: fixed encoder clocks per caption bit, less one
	localparam logic [7:0] CAPTION_BIT_CYCLES = 8'h3f;
	localparam int         CAPTION_BITS       = 16;
	localparam int         FIFO_DEPTH         = 8;
	localparam int         FIFO_WIDTH         = 14;
endpackage

// ### design/word_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_in,
	input  wire logic             resetn_in,
	input  wire logic             enable_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	wire              push = in_valid_in && in_ready_out;
	wire              pop  = out_valid_out && out_ready_in;

	assign in_ready_out  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_out = (count_reg != '0);
	assign out_data_out  = mem_reg[rd_ptr_reg];

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else if (enable_in) begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (enable_in && push)
			mem_reg[wr_ptr_reg] <= in_data_in;
	end
endmodule
`default_nettype wire

// ### design/vbi_insert.sv
// Caption and wide-screen signalling inserter with coefficient stores
`timescale 1ns/100ps
`default_nettype none
module vbi_insert (
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	input  wire logic        clk_en_in,
	// Register port, offsets relative to the mapped register base
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic [19:0] reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	output logic      [31:0] reg_rdata_out,
	// Line timing from the encoder
	input  wire logic        line_start_in,
	input  wire logic [5:0]  line_number_in,
	input  wire logic        field_id_in,
	input  wire logic [9:0]  h_position_in,
	// Coefficient read port for the scaling filters
	input  wire logic [1:0]  coeff_sel_in,
	input  wire logic [5:0]  coeff_word_in,
	output logic      [31:0] coeff_word_out,
	// Inserted data toward the DAC path
	output logic             vbi_active_out,
	output logic             vbi_level_out
);
	//==========================================================
	// Decode
	function automatic logic hit(input logic [19:0] a, input logic [19:0] o);
		hit = (a == o);
	endfunction

	function automatic logic in_store(input logic [19:0] a,
		input logic [19:0] base, input int words);
		in_store = (a >= base) && (a < base + 20'(words * 4)) &&
			(a[1:0] == 2'b00);
	endfunction

	wire        sel_cc_ctl  = hit(reg_addr_in, vbi_insert_pkg::CAPTION_CONTROL);
	wire        sel_cc_one  = hit(reg_addr_in, vbi_insert_pkg::CAPTION_DATA_ONE);
	wire        sel_cc_two  = hit(reg_addr_in, vbi_insert_pkg::CAPTION_DATA_TWO);
	wire        sel_wss_ctl = hit(reg_addr_in, vbi_insert_pkg::WIDESCREEN_CONTROL);
	wire        sel_wss_dat = hit(reg_addr_in, vbi_insert_pkg::WIDESCREEN_PAYLOAD);
	wire [3:0]  sel_store;
	assign sel_store[0] = in_store(reg_addr_in, vbi_insert_pkg::HORIZ_LUMA_BASE,
		vbi_insert_pkg::HORIZ_WORDS);
	assign sel_store[1] = in_store(reg_addr_in, vbi_insert_pkg::HORIZ_CHROMA_BASE,
		vbi_insert_pkg::HORIZ_WORDS);
	assign sel_store[2] = in_store(reg_addr_in, vbi_insert_pkg::VERT_LUMA_BASE,
		vbi_insert_pkg::VERT_WORDS);
	assign sel_store[3] = in_store(reg_addr_in, vbi_insert_pkg::VERT_CHROMA_BASE,
		vbi_insert_pkg::VERT_WORDS);
	wire [5:0]  store_idx = reg_addr_in[7:2];

	//==========================================================
	// Control registers
	logic [31:0] cc_ctl_reg;
	logic [31:0] wss_ctl_reg;
	logic [13:0] widescreen_payload_reg;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cc_ctl_reg   <= vbi_insert_pkg::REG_RESET;
			wss_ctl_reg  <= vbi_insert_pkg::REG_RESET;
			widescreen_payload_reg <= '0;
		end else if (clk_en_in && reg_wr_in) begin
			if (sel_cc_ctl)
				cc_ctl_reg <= reg_wdata_in & 32'h8bff_003f;
			if (sel_wss_ctl)
				wss_ctl_reg <= reg_wdata_in & 32'hc3ff_7f3f;
			if (sel_wss_dat)
				widescreen_payload_reg <= reg_wdata_in[13:0];
		end
	end

	wire       cc_enable   = cc_ctl_reg[vbi_insert_pkg::ENABLE_BIT];
	wire       cc_field    = cc_ctl_reg[vbi_insert_pkg::CC_FIELD_BIT];
	wire [9:0] cc_offset   = cc_ctl_reg[25:16];
	wire [5:0] caption_line_select     = cc_ctl_reg[5:0];
	wire       wss_enable  = wss_ctl_reg[vbi_insert_pkg::ENABLE_BIT];
	wire       widescreen_field_select   = wss_ctl_reg[vbi_insert_pkg::WIDESCREEN_FIELD_SELECT_BIT];
	wire [9:0] wss_offset  = wss_ctl_reg[25:16];
	wire [6:0] wss_divider = wss_ctl_reg[14:8];
	wire [5:0] widescreen_line_select    = wss_ctl_reg[5:0];

	//==========================================================
	// Coefficient stores, reset to zero
	logic [31:0] coeff_mem_reg [4][64];
	genvar gs;
	genvar gw;
	generate
		for (gs = 0; gs < 4; gs++) begin : g_store
			for (gw = 0; gw < 64; gw++) begin : g_word
				always_ff @(posedge clk_in or negedge resetn_in) begin
					if (!resetn_in)
						coeff_mem_reg[gs][gw] <= '0;
					else if (clk_en_in && reg_wr_in && sel_store[gs] &&
						store_idx == 6'(gw))
						coeff_mem_reg[gs][gw] <= reg_wdata_in;
				end
			end
		end
	endgenerate

	// Words hold coefficient pairs in sign/exponent/mantissa form
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			coeff_word_out <= '0;
		else if (clk_en_in)
			coeff_word_out <= coeff_mem_reg[coeff_sel_in][coeff_word_in];
	end

	//==========================================================
	// Caption queues, one per field
	logic [1:0]  q_in_ready;
	logic [1:0]  q_out_valid;
	logic [1:0]  q_pop;
	logic [13:0] q_data [2];
	wire  [1:0]  q_push = {sel_cc_two, sel_cc_one} & {2{reg_wr_in}};

	generate
		for (gs = 0; gs < 2; gs++) begin : g_queue
			word_fifo #(
				.WIDTH (vbi_insert_pkg::FIFO_WIDTH),
				.DEPTH (vbi_insert_pkg::FIFO_DEPTH)
			) u_queue (
				.clk_in        (clk_in),
				.resetn_in     (resetn_in),
				.enable_in     (clk_en_in),
				.in_valid_in   (q_push[gs]),
				.in_ready_out  (q_in_ready[gs]),
				.in_data_in    ({reg_wdata_in[14:8], reg_wdata_in[6:0]}),
				.out_valid_out (q_out_valid[gs]),
				.out_ready_in  (q_pop[gs]),
				.out_data_out  (q_data[gs])
			);
		end
	endgenerate

	//==========================================================
	// Read mux
	wire [31:0] rd_mux =
		sel_cc_ctl  ? cc_ctl_reg :
		sel_cc_one  ? {~q_in_ready[0], 31'h0} :
		sel_cc_two  ? {~q_in_ready[1], 31'h0} :
		sel_wss_ctl ? wss_ctl_reg :
		sel_wss_dat ? {18'h0, widescreen_payload_reg} :
		sel_store[0] ? coeff_mem_reg[0][store_idx] :
		sel_store[1] ? coeff_mem_reg[1][store_idx] :
		sel_store[2] ? coeff_mem_reg[2][store_idx] :
		sel_store[3] ? coeff_mem_reg[3][store_idx] : 32'h0;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			reg_rdata_out <= '0;
		else if (clk_en_in && reg_rd_in)
			reg_rdata_out <= rd_mux;
	end

	//==========================================================
	// Line timing inputs are from the encoder clock domain
	typedef enum logic [2:0] {
		IDLE_S = 3'b001,
		WAIT_S = 3'b010,
		SEND_S = 3'b100
	} ins_state_t;

	ins_state_t  state_reg;
	logic        is_wss_reg;
	logic [15:0] shift_reg;
	logic [4:0]  bits_left_reg;
	logic [7:0]  bit_cnt_reg;
	logic        cc_field_sel_reg;

	// Caption field 0 selects the queue matching the current field id
	wire cc_q      = field_id_in ^ cc_field;
	wire cc_go     = cc_enable && line_number_in == caption_line_select &&
		q_out_valid[cc_q];
	wire wss_go    = wss_enable && line_number_in == widescreen_line_select &&
		field_id_in == ~widescreen_field_select;
	wire [9:0] target = is_wss_reg ? wss_offset : cc_offset;
	wire [7:0] bit_len = is_wss_reg ? {1'b0, wss_divider} :
		vbi_insert_pkg::CAPTION_BIT_CYCLES;
	wire bit_done  = (bit_cnt_reg == 8'h00);

	assign q_pop[0] = line_start_in && state_reg == IDLE_S && !wss_go &&
		cc_go && !cc_q;
	assign q_pop[1] = line_start_in && state_reg == IDLE_S && !wss_go &&
		cc_go && cc_q;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_reg        <= IDLE_S;
			is_wss_reg       <= 1'b0;
			shift_reg        <= '0;
			bits_left_reg    <= '0;
			bit_cnt_reg      <= '0;
			cc_field_sel_reg <= 1'b0;
		end else if (clk_en_in) begin
			unique case (state_reg)
				IDLE_S: if (line_start_in && (wss_go || cc_go)) begin
					is_wss_reg    <= wss_go;
					state_reg     <= WAIT_S;
					cc_field_sel_reg <= cc_q;
					shift_reg     <= wss_go ? {2'b00, widescreen_payload_reg} :
						{1'b0, q_data[cc_q][13:7], 1'b0, q_data[cc_q][6:0]};
					bits_left_reg <= wss_go ?
						5'(vbi_insert_pkg::WIDESCREEN_PAYLOAD_W) :
						5'(vbi_insert_pkg::CAPTION_BITS);
				end
				WAIT_S: if (h_position_in == target) begin
					state_reg   <= SEND_S;
					bit_cnt_reg <= bit_len;
				end
				SEND_S: if (bit_done) begin
					bit_cnt_reg <= bit_len;
					shift_reg   <= {1'b0, shift_reg[15:1]};
					bits_left_reg <= bits_left_reg - 5'd1;
					if (bits_left_reg == 5'd1)
						state_reg <= IDLE_S;
				end else begin
					bit_cnt_reg <= bit_cnt_reg - 8'd1;
				end
				default: state_reg <= IDLE_S;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			vbi_active_out <= 1'b0;
			vbi_level_out  <= 1'b0;
		end else if (clk_en_in) begin
			vbi_active_out <= (state_reg == SEND_S);
			vbi_level_out  <= (state_reg == SEND_S) && shift_reg[0];
		end
	end

	//==========================================================
	// Checks
	a_disabled_no_pop: assert property (@(posedge clk_in) disable iff (!resetn_in)
		!cc_enable |-> q_pop == 2'b00) else $error("caption popped when off");
	a_widescreen_field_select_gate: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(clk_en_in && state_reg == IDLE_S && line_start_in && wss_go) |=> is_wss_reg)
		else $error("signalling not started");
	a_full_flag_read: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(clk_en_in && reg_rd_in && sel_cc_one) |=>
		reg_rdata_out[31] == $past(~q_in_ready[0])) else $error("full flag wrong");
	a_payload_width: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(clk_en_in && reg_rd_in && sel_wss_dat) |=> reg_rdata_out[31:14] == 18'h0)
		else $error("payload upper bits set");
	a_bit_period: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(clk_en_in && state_reg == WAIT_S && h_position_in == target && is_wss_reg)
		|=> bit_cnt_reg == {1'b0, wss_divider}) else $error("bit period wrong");
	a_line_match: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(q_pop != 2'b00) |-> line_number_in == caption_line_select) else $error("wrong line");
	a_store_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(clk_en_in && reg_wr_in && sel_store[0]) |=>
		coeff_mem_reg[0][$past(store_idx)] == $past(reg_wdata_in))
		else $error("store write lost");
	a_offset_wait: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(state_reg == WAIT_S && h_position_in != target) |=> state_reg != SEND_S)
		else $error("run-in early");
	a_unmapped_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(clk_en_in && reg_rd_in && reg_addr_in == vbi_insert_pkg::BLOCK_BASE) |=>
		reg_rdata_out == 32'h0) else $error("unmapped read nonzero");
endmodule
`default_nettype wire

// ### test/line_timing_model.sv
// Encoder line timing stand-in: one line of positions per go pulse
`timescale 1ns/100ps
`default_nettype none
module line_timing_model #(
	parameter int LINE_LEN = 1250
) (
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	input  wire logic       go_in,
	input  wire logic [5:0] line_in,
	input  wire logic       field_in,
	output logic            line_start_out,
	output logic      [5:0] line_number_out,
	output logic            field_id_out,
	output logic      [9:0] h_position_out
);
	logic [10:0] count_reg;
	assign h_position_out = count_reg[9:0];
	// Lines carry no picture, so the signalling line stays blank
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			count_reg       <= 11'(LINE_LEN);
			line_start_out  <= 1'b0;
			line_number_out <= 6'h00;
			field_id_out    <= 1'b0;
		end else if (go_in) begin
			count_reg       <= 11'h000;
			line_start_out  <= 1'b1;
			line_number_out <= line_in;
			field_id_out    <= field_in;
		end else begin
			line_start_out <= 1'b0;
			// Position stands still between lines
			if (count_reg < 11'(LINE_LEN)) begin
				count_reg <= count_reg + 11'h001;
			end
		end
	end
endmodule
`default_nettype wire

// ### test/test_vbi_insert.sv
// Register-level testbench for the caption and signalling inserter
`timescale 1ns/100ps
`default_nettype none
module test_vbi_insert;
	logic        clk_in = 1'b0;
	logic        clk_en_in = 1'b1;
	logic        resetn_in = 1'b0;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic [19:0] reg_addr_in = 20'h00000;
	logic [31:0] reg_wdata_in = 32'h0;
	logic [31:0] reg_rdata_out;
	logic        line_start_in;
	logic [5:0]  line_number_in;
	logic        field_id_in;
	logic [9:0]  h_position_in;
	logic [1:0]  coeff_sel_in = 2'h0;
	logic [5:0]  coeff_word_in = 6'h00;
	logic [31:0] coeff_word_out;
	logic        vbi_active_out;
	logic        vbi_level_out;
	logic        go = 1'b0;
	logic [5:0]  line_req = 6'h00;
	logic        field_req = 1'b0;
	int          bad_count = 0;
	int          n_compared = 0;
	logic [15:0] bits;
	logic [9:0]  h0;
	logic [19:0] a;
	logic [31:0] pat;
	int          len;
	int          n;

	vbi_insert i_vbi_insert (.clk_in(clk_in), .resetn_in(resetn_in),
		.clk_en_in(clk_en_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_rdata_out(reg_rdata_out), .line_start_in(line_start_in),
		.line_number_in(line_number_in), .field_id_in(field_id_in),
		.h_position_in(h_position_in), .coeff_sel_in(coeff_sel_in),
		.coeff_word_in(coeff_word_in), .coeff_word_out(coeff_word_out),
		.vbi_active_out(vbi_active_out), .vbi_level_out(vbi_level_out));
	line_timing_model i_line_timing_model (.clk_in(clk_in),
		.resetn_in(resetn_in), .go_in(go), .line_in(line_req),
		.field_in(field_req), .line_start_out(line_start_in),
		.line_number_out(line_number_in), .field_id_out(field_id_in),
		.h_position_out(h_position_in));

	always #2.5 clk_in = ~clk_in;

	// ==========================================
	// Access tasks and compares
	task automatic wr(input logic [19:0] ad, input logic [31:0] d);
		@(negedge clk_in);
		reg_addr_in = ad;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		@(negedge clk_in);
		reg_wr_in = 1'b0;
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t word got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [19:0] ad, input logic [31:0] exp);
		@(negedge clk_in);
		reg_addr_in = ad;
		reg_rd_in = 1'b1;
		@(negedge clk_in);
		reg_rd_in = 1'b0;
		@(negedge clk_in);
		chk_reg(reg_rdata_out, exp);
	endtask
	// Runs one line and collects the inserted bits, one sample per bit
	task automatic run_line(input logic [5:0] ln, input logic fd,
			input int per);
		@(negedge clk_in);
		line_req = ln;
		field_req = fd;
		go = 1'b1;
		@(negedge clk_in);
		go = 1'b0;
		bits = 16'h0;
		len = 0;
		h0 = 10'h0;
		repeat (1300) begin
			@(negedge clk_in);
			if (vbi_active_out === 1'b1) begin
				if (len == 0) h0 = h_position_in;
				if (len % per == per / 2) bits[len / per] = vbi_level_out;
				len++;
			end
		end
	endtask
	task automatic chk_serial(input logic [15:0] eb, input int el,
			input logic [9:0] off);
		n_compared++;
		if (bits !== eb || len != el || (el != 0 &&
				(h0 <= off || 11'(h0) > 11'(off) + 11'h002))) begin
			bad_count++;
			$display("[FAIL] %0t serial got %h/%0d/%0d exp %h/%0d/%0d",
				$time, bits, len, h0, eb, el, off);
		end
	endtask
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge clk_in);
		bad_count++;
		conclude();
	end

	// ==========================================
	// Test sequence
	initial begin
		repeat (6) @(negedge clk_in);
		resetn_in = 1'b1;
		rchk(vbi_insert_pkg::CAPTION_CONTROL, 32'h0);
		rchk(vbi_insert_pkg::CAPTION_DATA_TWO, 32'h0);
		rchk(vbi_insert_pkg::WIDESCREEN_CONTROL, 32'h0);
		rchk(vbi_insert_pkg::WIDESCREEN_PAYLOAD, 32'h0);
		for (int s = 0; s < 4; s++) begin
			n = (s < 2) ? vbi_insert_pkg::HORIZ_WORDS : vbi_insert_pkg::VERT_WORDS;
			a = vbi_insert_pkg::HORIZ_LUMA_BASE + 20'(s * 256 + 4 * (n - 1));
			pat = 32'h9c40_1a00 ^ (32'(s) << 28);
			rchk(a, 32'h0);
			wr(a, pat);
			rchk(a, pat);
			coeff_sel_in = 2'(s);
			coeff_word_in = 6'(n - 1);
			repeat (2) @(negedge clk_in);
			chk_reg(coeff_word_out, pat);
			wr(a + 20'h4, pat);
			rchk(a + 20'h4, 32'h0);
		end
		wr(vbi_insert_pkg::CAPTION_CONTROL, 32'hffff_ffff);
		rchk(vbi_insert_pkg::CAPTION_CONTROL, 32'h8bff_003f);
		wr(vbi_insert_pkg::WIDESCREEN_CONTROL, 32'hffff_ffff);
		rchk(vbi_insert_pkg::WIDESCREEN_CONTROL, 32'hc3ff_7f3f);
		wr(vbi_insert_pkg::WIDESCREEN_PAYLOAD, 32'hffff_ffff);
		rchk(vbi_insert_pkg::WIDESCREEN_PAYLOAD, 32'h0000_3fff);
		wr(20'h680a0, 32'hffff_ffff);
		rchk(20'h680a0, 32'h0);
		rchk(20'h08090, 32'h0);
		rchk(vbi_insert_pkg::BLOCK_BASE, 32'h0);
		wr(vbi_insert_pkg::WIDESCREEN_CONTROL, 32'h0);
		wr(vbi_insert_pkg::CAPTION_CONTROL, 32'h0087_0015);
		// Fill the field one queue until it refuses
		for (int i = 0; i < vbi_insert_pkg::FIFO_DEPTH; i++) begin
			rchk(vbi_insert_pkg::CAPTION_DATA_ONE, 32'h0);
			wr(vbi_insert_pkg::CAPTION_DATA_ONE, 32'h3041 + 32'(i) * 32'h0101);
		end
		rchk(vbi_insert_pkg::CAPTION_DATA_ONE, 32'h8000_0000);
		wr(vbi_insert_pkg::CAPTION_DATA_ONE, 32'h0000_5a5a);
		rchk(vbi_insert_pkg::CAPTION_DATA_ONE, 32'h8000_0000);
		rchk(vbi_insert_pkg::CAPTION_DATA_TWO, 32'h0);
		run_line(6'd21, 1'b0, 64);
		chk_serial(16'h0, 0, 10'd135);
		wr(vbi_insert_pkg::CAPTION_CONTROL, 32'h8087_0015);
		run_line(6'd20, 1'b0, 64);
		chk_serial(16'h0, 0, 10'd135);
		run_line(6'd21, 1'b0, 64);
		chk_serial(16'h3041, 1024, 10'd135);
		rchk(vbi_insert_pkg::CAPTION_DATA_ONE, 32'h0);
		run_line(6'd21, 1'b0, 64);
		chk_serial(16'h3142, 1024, 10'd135);
		wr(vbi_insert_pkg::CAPTION_CONTROL, 32'h8887_0015);
		run_line(6'd21, 1'b0, 64);
		chk_serial(16'h0, 0, 10'd135);
		run_line(6'd21, 1'b1, 64);
		chk_serial(16'h3243, 1024, 10'd135);
		wr(vbi_insert_pkg::WIDESCREEN_PAYLOAD, 32'h0000_2a5c);
		wr(vbi_insert_pkg::WIDESCREEN_CONTROL, 32'hc094_0319);
		run_line(6'd25, 1'b1, 4);
		chk_serial(16'h0, 0, 10'd148);
		run_line(6'd25, 1'b0, 4);
		chk_serial(16'h2a5c, 56, 10'd148);
		wr(vbi_insert_pkg::WIDESCREEN_CONTROL, 32'hc094_1b19);
		run_line(6'd25, 1'b0, 28);
		chk_serial(16'h2a5c, 392, 10'd148);
		wr(vbi_insert_pkg::WIDESCREEN_CONTROL, 32'h4094_1b19);
		run_line(6'd25, 1'b0, 28);
		chk_serial(16'h0, 0, 10'd148);
		// Clock enable low must freeze the payload register
		clk_en_in = 1'b0;
		wr(vbi_insert_pkg::WIDESCREEN_PAYLOAD, 32'h0000_1111);
		clk_en_in = 1'b1;
		rchk(vbi_insert_pkg::WIDESCREEN_PAYLOAD, 32'h0000_2a5c);
		conclude();
	end
endmodule
`default_nettype wire
